// >>> core/sftp_core.v
// Serial file transfer engine with AXI4-Lite register slave
`timescale 1ns/100ps
`include "sftp_map.vh"
module sftp_core (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write channels
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read channels
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Byte stream to serial port
	output reg [7:0] tx_data,
	output reg tx_valid,
	input wire tx_ready,
	// Byte stream from serial port
	input wire [7:0] rx_data,
	input wire rx_valid,
	output wire rx_ready,
	// Hardware handshake line
	output reg link_rts
);
	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam S_IDLE = 4'h0;
	localparam S_NUL = 4'h1;
	localparam S_SEQ = 4'h2;
	localparam S_XON = 4'h3;
	localparam S_RX = 4'h4;
	localparam S_OUT = 4'h5;
	localparam S_START = 4'h6;
	localparam S_BODY = 4'h7;
	localparam S_ETB = 4'h8;
	localparam S_BCC = 4'h9;
	localparam S_XONB = 4'ha;
	localparam S_WACK = 4'hb;
	localparam S_ETX = 4'hc;
	localparam S_EOT = 4'hd;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Directory request characters
	function [7:0] dseq;
		input [2:0] i;
		begin
			case (i) // RQ25
			3'h0: dseq = `SFTP_XOFF;
			3'h1: dseq = 8'h1b;
			3'h2: dseq = `SFTP_XON;
			3'h3: dseq = 8'h30;
			3'h4: dseq = 8'h20;
			3'h5: dseq = 8'h44;
			3'h6: dseq = 8'h0d;
			default: dseq = 8'h0a;
			endcase
		end
	endfunction

	// Byte lane merge for register writes
	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] st;
		integer k;
		begin
			wmerge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (st[k])
					wmerge[k*8 +: 8] = nw[k*8 +: 8];
			end
		end
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg [31:0] ctrl_q; // Mode and options
	reg [31:0] cha_q; // SOH STX ETB ACK
	reg [31:0] chb_q; // NAK ETX EOT
	reg cmd_go_q; // One-cycle command pulse
	reg [3:0] cmd_q; // Op and header flag
	reg txw_q; // Text byte written
	reg [7:0] txw_d8_q; // Written text byte
	reg pop_q; // Receive byte read
	reg aw_q; // Write address held
	reg [7:0] awa_q;
	reg w_q; // Write data held
	reg [31:0] wd_q;
	reg [3:0] ws_q;
	reg [3:0] st_q; // Engine state
	reg [5:0] idx_q; // Count or buffer index
	reg [7:0] buf_q [0:15]; // Frame text for resend
	reg [4:0] cnt_q; // Text bytes held
	reg [7:0] txh_q; // Plain stream byte
	reg txh_v_q;
	reg [6:0] bcc_q; // Outgoing check char
	reg [1:0] retry_q; // NAK count
	reg hdr_q; // Frame is a header
	reg err_q; // Error E, sticky
	reg paused_q; // Peer sent XOFF
	reg [7:0] rxh_q; // Received byte
	reg rxh_v_q;
	reg etx_q; // ETX seen, sticky
	reg lead_q; // Leading NULs dropped
	reg thr_q; // XOFF sent to peer
	reg fr_q; // Inside inbound frame
	reg bw_q; // Awaiting inbound check
	reg [6:0] rbcc_q; // Inbound check char
	reg ack_p_q; // ACK to send
	reg nak_p_q; // NAK to send

	// ------------------------------------------------------------
	// Decoded controls
	// ------------------------------------------------------------
	wire [1:0] mode = ctrl_q[1:0];
	wire xon_bcc = ctrl_q[2]; // XON after check char option
	wire hw_hs = ctrl_q[3]; // RTS handshake
	wire cfg_bcc = ctrl_q[4]; // Checked protocol in mode 3
	wire cfg = (mode == `SFTP_M_CFG);
	wire fix7 = (mode == `SFTP_M_DIR) || (mode == `SFTP_M_FIX);
	wire chk = fix7 || (cfg && cfg_bcc);
	// Control characters, programmable only in mode 3
	wire [7:0] c_soh = cfg ? cha_q[7:0] : 8'h01; // RQ22
	wire [7:0] c_stx = cfg ? cha_q[15:8] : 8'h02;
	wire [7:0] c_etb = cfg ? cha_q[23:16] : 8'h17;
	wire [7:0] c_ack = cfg ? cha_q[31:24] : 8'h06;
	wire [7:0] c_nak = cfg ? chb_q[7:0] : 8'h15;
	wire [7:0] c_etx = cfg ? chb_q[15:8] : 8'h03;
	wire [7:0] c_eot = cfg ? chb_q[23:16] : 8'h04;
	// Seven data bits in the fixed checked modes
	wire [7:0] rxb = fix7 ? {1'b0, rx_data[6:0]} : rx_data; // RQ24
	wire rx_take = rx_valid && rxh_v_q == 1'b0; // RQ27
	wire rx_on = (st_q == S_RX);
	// Plain throttle wants
	wire want_off = rx_on && !chk && !hw_hs && rxh_v_q && !thr_q; // RQ9
	wire want_on = !chk && thr_q && !rxh_v_q; // RQ6

	assign rx_ready = !rxh_v_q;

	// ------------------------------------------------------------
	// Next outgoing engine character
	// ------------------------------------------------------------
	reg [7:0] ech; // Character for current state
	reg ewant; // State has one to send
	always @* begin
		ech = 8'h00;
		ewant = 1'b1;
		case (st_q)
		S_NUL: ech = `SFTP_NUL; // RQ23
		S_SEQ: ech = dseq(idx_q[2:0]);
		S_XON: ech = `SFTP_XON;
		S_OUT: begin
			ech = txh_q;
			ewant = txh_v_q;
		end
		S_START: ech = hdr_q ? c_soh : c_stx; // RQ11 RQ17
		S_BODY: ech = buf_q[idx_q[3:0]];
		S_ETB: ech = c_etb;
		S_BCC: ech = {1'b0, bcc_q};
		S_XONB: ech = `SFTP_XON;
		S_ETX: ech = c_etx;
		S_EOT: ech = c_eot;
		default: ewant = 1'b0;
		endcase
	end

	// Peer XOFF holds plain output, replies excepted
	wire eblock = paused_q && !chk; // RQ3

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready = !w_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire wr_go = aw_q && w_q && !s_axi_bvalid;
	wire [31:0] stat_w = {17'h00000, cnt_q, retry_q, rxh_v_q,
		paused_q, etx_q, err_q, st_q};

	// Address and data capture, register writes and reads
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			awa_q <= 8'h00;
			w_q <= 1'b0;
			wd_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h0000_0000;
			ctrl_q <= `SFTP_CTRL_RST;
			cha_q <= `SFTP_CHA_RST;
			chb_q <= `SFTP_CHB_RST;
			cmd_go_q <= 1'b0;
			cmd_q <= 4'h0;
			txw_q <= 1'b0;
			txw_d8_q <= 8'h00;
			pop_q <= 1'b0;
		end else begin
			cmd_go_q <= 1'b0;
			txw_q <= 1'b0;
			pop_q <= 1'b0;
			// Channels taken in either order
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awa_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			// Write once both halves are in
			if (wr_go) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				case ({awa_q[7:2], 2'h0})
				`SFTP_CTRL: ctrl_q <= wmerge(ctrl_q, wd_q, ws_q);
				`SFTP_CHA: cha_q <= wmerge(cha_q, wd_q, ws_q);
				`SFTP_CHB: chb_q <= wmerge(chb_q, wd_q, ws_q);
				`SFTP_CMD: begin
					cmd_go_q <= ws_q[0];
					cmd_q <= wd_q[3:0];
				end
				`SFTP_TXD: begin
					txw_q <= ws_q[0];
					txw_d8_q <= wd_q[7:0];
				end
				`SFTP_STAT, `SFTP_RXD: s_axi_bresp <= 2'h0;
				default: s_axi_bresp <= 2'h2;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			// Read, with pop side effect on the receive byte
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case ({s_axi_araddr[7:2], 2'h0})
				`SFTP_CTRL: s_axi_rdata <= ctrl_q;
				`SFTP_CHA: s_axi_rdata <= cha_q;
				`SFTP_CHB: s_axi_rdata <= chb_q;
				`SFTP_STAT: s_axi_rdata <= stat_w;
				`SFTP_CMD, `SFTP_TXD: s_axi_rdata <= 32'h0000_0000;
				`SFTP_RXD: begin
					s_axi_rdata <= {23'h000000, rxh_v_q, rxh_q};
					pop_q <= 1'b1;
				end
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Protocol engine
	// ------------------------------------------------------------
	integer i;
	always @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= S_IDLE;
			idx_q <= 6'h00;
			for (i = 0; i < 16; i = i + 1)
				buf_q[i] <= 8'h00;
			cnt_q <= 5'h00;
			txh_q <= 8'h00;
			txh_v_q <= 1'b0;
			bcc_q <= 7'h00;
			retry_q <= 2'h0;
			hdr_q <= 1'b0;
			err_q <= 1'b0;
			paused_q <= 1'b0;
			rxh_q <= 8'h00;
			rxh_v_q <= 1'b0;
			etx_q <= 1'b0;
			lead_q <= 1'b0;
			thr_q <= 1'b0;
			fr_q <= 1'b0;
			bw_q <= 1'b0;
			rbcc_q <= 7'h00;
			ack_p_q <= 1'b0;
			nak_p_q <= 1'b0;
			tx_data <= 8'h00;
			tx_valid <= 1'b0;
			link_rts <= 1'b1;
		end else begin
			// Software side pops and text writes
			if (pop_q)
				rxh_v_q <= 1'b0;
			if (txw_q) begin
				if (st_q == S_OUT) begin
					txh_q <= txw_d8_q;
					txh_v_q <= 1'b1;
				end else if (cnt_q != `SFTP_BUF_LEN) begin
					buf_q[cnt_q[3:0]] <= txw_d8_q;
					cnt_q <= cnt_q + 5'h01;
				end
			end
			// RTS drops while the receive byte is unread
			link_rts <= !(rx_on && hw_hs && rxh_v_q); // RQ10
			// Commands
			if (cmd_go_q) begin
				idx_q <= 6'h00;
				hdr_q <= cmd_q[3];
				case (cmd_q[2:0])
				`SFTP_OP_CLR: begin
					err_q <= 1'b0;
					etx_q <= 1'b0;
					cnt_q <= 5'h00;
					st_q <= S_IDLE;
				end
				`SFTP_OP_DIR: begin
					// Mode 1 emits its request first
					if (mode == `SFTP_M_DIR)
						st_q <= S_SEQ; // RQ21
					else if (chk)
						st_q <= S_START;
					else
						st_q <= S_XON; // RQ1
				end
				`SFTP_OP_ABORT: st_q <= S_ETX; // RQ2
				`SFTP_OP_OUT: st_q <= chk ? S_START : S_NUL;
				`SFTP_OP_FRAME: begin
					retry_q <= 2'h0;
					st_q <= S_START;
				end
				`SFTP_OP_IN: st_q <= S_XON; // RQ5 RQ8
				`SFTP_OP_FIN: st_q <= S_ETX; // RQ19
				default: st_q <= S_EOT; // RQ5 RQ20
				endcase
			end
			// Inbound byte
			if (rx_take) begin
				if (!chk) begin
					if (rxb == `SFTP_XOFF)
						paused_q <= 1'b1; // RQ3
					else if (rxb == `SFTP_XON)
						paused_q <= 1'b0;
					else if (!(lead_q && rxb == `SFTP_NUL)) begin
						lead_q <= 1'b0; // RQ23
						rxh_q <= rxb;
						rxh_v_q <= 1'b1;
						if (rxb == c_etx)
							etx_q <= 1'b1; // RQ7 RQ8
					end
				end else if (bw_q) begin
					bw_q <= 1'b0;
					// Compare computed and received check
					if (rxb[6:0] == rbcc_q)
						ack_p_q <= 1'b1; // RQ15
					else
						nak_p_q <= 1'b1; // RQ16
				end else if (fr_q) begin
					rbcc_q <= rbcc_q ^ rxb[6:0]; // RQ12
					if (rxb == c_etb) begin
						fr_q <= 1'b0;
						bw_q <= 1'b1;
					end else begin
						rxh_q <= rxb; // RQ26
						rxh_v_q <= 1'b1;
					end
				end else if (rxb == c_soh || rxb == c_stx) begin
					fr_q <= 1'b1;
					rbcc_q <= rxb[6:0];
				end else if (st_q == S_WACK && rxb == c_ack) begin
					cnt_q <= 5'h00; // RQ18
					retry_q <= 2'h0;
					st_q <= S_IDLE;
				end else if (st_q == S_WACK && rxb == c_nak) begin
					if (retry_q == `SFTP_RETRY_MAX) begin
						err_q <= 1'b1; // RQ16
						st_q <= S_EOT; // RQ20
					end else begin
						retry_q <= retry_q + 2'h1;
						idx_q <= 6'h00;
						st_q <= S_START; // RQ18
					end
				end else if (rxb != `SFTP_XON) begin
					// Plain lines such as directory text
					rxh_q <= rxb; // RQ14
					rxh_v_q <= 1'b1;
					if (rxb == c_etx)
						etx_q <= 1'b1;
				end
			end
			// Output register hand-off
			if (tx_valid && tx_ready)
				tx_valid <= 1'b0;
			else if (!tx_valid && !cmd_go_q) begin
				// ACK held back until the byte is read
				if (ack_p_q && !rxh_v_q) begin
					tx_data <= c_ack; // RQ22
					tx_valid <= 1'b1;
					ack_p_q <= 1'b0;
				end else if (nak_p_q) begin
					tx_data <= c_nak; // RQ16
					tx_valid <= 1'b1;
					nak_p_q <= 1'b0;
				end else if (want_off) begin
					tx_data <= `SFTP_XOFF; // RQ9
					tx_valid <= 1'b1;
					thr_q <= 1'b1;
				end else if (want_on) begin
					tx_data <= `SFTP_XON; // RQ6
					tx_valid <= 1'b1;
					thr_q <= 1'b0;
				end else if (ewant && !eblock) begin
					tx_data <= fix7 ? {1'b0, ech[6:0]} : ech;
					tx_valid <= 1'b1;
					case (st_q)
					S_NUL: begin
						idx_q <= idx_q + 6'h01;
						if (idx_q == `SFTP_NUL_CNT - 6'h01)
							st_q <= S_OUT; // RQ23
					end
					S_SEQ: begin
						idx_q <= idx_q + 6'h01;
						if (idx_q == 6'h07)
							st_q <= S_RX;
					end
					S_XON: begin
						st_q <= S_RX; // RQ1 RQ5
						lead_q <= 1'b1;
						// Inbound ETX in the same cycle wins
						if (!(rx_take && rxb == c_etx))
							etx_q <= 1'b0;
					end
					// Stream continues until software finishes
					S_OUT: txh_v_q <= 1'b0; // RQ4
					S_START: begin
						bcc_q <= ech[6:0]; // RQ12
						idx_q <= 6'h00;
						st_q <= (cnt_q == 5'h00) ? S_ETB : S_BODY;
					end
					S_BODY: begin
						bcc_q <= bcc_q ^ ech[6:0];
						idx_q <= idx_q + 6'h01;
						if (idx_q[4:0] == cnt_q - 5'h01)
							st_q <= S_ETB;
					end
					S_ETB: begin
						bcc_q <= bcc_q ^ ech[6:0]; // RQ12
						st_q <= S_BCC;
					end
					S_BCC: begin
						// XON may be switched off in mode 3
						if (cfg && !xon_bcc)
							st_q <= S_WACK; // RQ13
						else
							st_q <= S_XONB; // RQ17
					end
					S_XONB: st_q <= S_WACK;
					S_ETX: st_q <= S_EOT; // RQ2 RQ19
					default: st_q <= S_IDLE;
					endcase
				end
			end
		end
	end
endmodule // sftp_core

// >>> core/sftp_map.vh
// Register map, characters and counts of the serial file transfer engine
// Contract
// (RQ1) Directory request: send XON, read program stream
// (RQ2) Abort request: send ETX then EOT only
// (RQ3) Peer XOFF halts output, XON resumes it
// (RQ4) Output all: files back to back
// (RQ5) Read-in: XON first, EOT when file done
// (RQ6) Read-in may throttle; keep reading on mismatch
// (RQ7) Name missing: wait for abort; ETX ends
// (RQ8) Read all: XON only after ETX
// (RQ9) Buffer full: XOFF, wait for confirmation
// (RQ10) Hardware handshake uses RTS instead
// (RQ11) Header frame: SOH, type, name, dir, ETB
// (RQ12) Check char: even column parity, start..ETB
// (RQ13) XON after check char off by config
// (RQ14) Peer needs no XON after check char
// (RQ15) Receiver compares check char, answers ACK
// (RQ16) NAK means resend; three retries, error E
// (RQ17) Blocks: STX, text, ETB, check, XON
// (RQ18) ACK advances, NAK resends block
// (RQ19) After last ACK send ETX, EOT
// (RQ20) EOT ends input and follows any error
// (RQ21) Directory mode emits request sequence first
// (RQ22) Programmable control chars; withheld ACK throttles
// (RQ23) Fifty NULs before plain output; ignore inbound
// (RQ24) Fixed checked modes use 7 data bits
// (RQ25) Request sequence XOFF ESC XON 0 SP D CR LF
// (RQ26) Peer error frame text shown to software
// (RQ27) Byte handshakes, no timeouts, command driven
`ifndef SFTP_MAP_VH
`define SFTP_MAP_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SFTP_CTRL 8'h00
`define SFTP_CMD 8'h04
`define SFTP_STAT 8'h08
`define SFTP_TXD 8'h0c
`define SFTP_RXD 8'h10
`define SFTP_CHA 8'h14
`define SFTP_CHB 8'h18
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SFTP_CTRL_RST 32'h0000_0004
`define SFTP_CHA_RST 32'h1506_0201
`define SFTP_CHB_RST 32'h0004_0315
// ----------------------------------------------------------------
// Modes and commands
// ----------------------------------------------------------------
`define SFTP_M_PLAIN 2'h0
`define SFTP_M_DIR 2'h1
`define SFTP_M_FIX 2'h2
`define SFTP_M_CFG 2'h3
`define SFTP_OP_CLR 3'h0
`define SFTP_OP_DIR 3'h1
`define SFTP_OP_ABORT 3'h2
`define SFTP_OP_OUT 3'h3
`define SFTP_OP_FRAME 3'h4
`define SFTP_OP_IN 3'h5
`define SFTP_OP_FIN 3'h6
`define SFTP_OP_INEND 3'h7
// ----------------------------------------------------------------
// Fixed characters and counts
// ----------------------------------------------------------------
`define SFTP_NUL 8'h00
`define SFTP_XON 8'h11
`define SFTP_XOFF 8'h13
`define SFTP_NUL_CNT 6'h32
`define SFTP_RETRY_MAX 2'h3
`define SFTP_BUF_LEN 5'h10
`endif

// >>> bench/sftp_core_chk.sv
// Port timing checker of the file transfer engine
`timescale 1ns/100ps
module sftp_core_chk (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Register bus
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// Byte streams
	input wire [7:0] tx_data,
	input wire tx_valid,
	input wire tx_ready,
	input wire rx_valid,
	input wire rx_ready
);
	// ------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Both write halves taken at one edge
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Engine byte taken by the port
	sequence s_tx;
		tx_valid && tx_ready;
	endsequence
	a_b_answer: assert property (s_wr |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid)
		else $error("read data missing");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_ar_free: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read address ready wrong");
	a_tx_hold: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data))
		else $error("byte withdrawn before taken");
	a_tx_gap: assert property (s_tx |=> !tx_valid)
		else $error("no idle cycle between bytes");
	a_rx_refuse: assert property ($rose(rx_ready) |-> $past(s_axi_rvalid))
		else $error("receive hold freed without a read");
endmodule // sftp_core_chk
bind sftp_core sftp_core_chk u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.rx_valid(rx_valid), .rx_ready(rx_ready));

// >>> bench/sftp_peer.sv
// Serial peer model: logs engine bytes, plays queued bytes back
`timescale 1ns/100ps
module sftp_peer (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Bytes from the engine
	input wire [7:0] tx_data,
	input wire tx_valid,
	output logic tx_ready,
	// Bytes to the engine
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire rx_ready
);
	logic [7:0] got [$]; // Bytes taken from the engine
	logic [7:0] snd [$]; // Bytes waiting to go out
	logic slow = 1'b0; // Stall every other cycle
	logic tk_q = 1'b0; // Engine byte taken at next edge
	logic rk_q = 1'b0; // Our byte taken at next edge
	logic [7:0] td_q = 8'h00; // Engine byte seen mid cycle
	// Sample handshakes mid cycle, clear of edge races
	always @(negedge aclk) begin
		tk_q <= tx_valid && tx_ready;
		rk_q <= rx_valid && rx_ready;
		td_q <= tx_data;
	end
	// Accept, log and send bytes
	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_ready <= 1'b0;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
		end else begin
			tx_ready <= slow ? !tx_ready : 1'b1;
			if (tk_q)
				got.push_back(td_q);
			// Hold until taken, scramble the idle line
			if (rk_q) begin
				rx_valid <= 1'b0;
				rx_data <= ~rx_data;
			end else if (!rx_valid && snd.size() != 0) begin
				rx_data <= snd.pop_front();
				rx_valid <= 1'b1;
			end else if (!rx_valid)
				rx_data <= ~rx_data;
		end
	end
endmodule // sftp_peer

// >>> bench/test_serial_file_transfer_protocol.sv
// Register driven bench of the file transfer engine
`timescale 1ns/100ps
`include "sftp_map.vh"
module test_serial_file_transfer_protocol;
	logic aclk = 1'b0; // Clock
	logic aresetn = 1'b0; // Reset, active low
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf; // Write lane strobes
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	wire awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] tx_data, rx_data;
	wire tx_valid, tx_ready, rx_valid, rx_ready, link_rts;
	logic [31:0] rd_v; // Last read word
	int num_errors = 0;
	int num_checks = 0;
	int i;
	logic [7:0] dir_seq [8] = '{8'h13, 8'h1b, 8'h11, 8'h30, 8'h20, 8'h44,
		8'h0d, 8'h0a}; // Directory request
	always #2.5 aclk = ~aclk;
	sftp_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .link_rts(link_rts));
	sftp_peer peer (.aclk(aclk), .aresetn(aresetn), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Verdict and end of run
	task print_verdict;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Compare seen against expected
	task chk(input [31:0] seen, input [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Bound ran out
	task to_out;
		num_errors++;
		print_verdict;
	endtask
	// Bus write; unmapped places answer an error code
	task automatic axw(input [7:0] a, input [31:0] d);
		logic ta, tw, tk;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tk = 1'b0;
		for (int n = 0; n < 200 && !tk; n++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tk = bvalid && bready;
			if (tk)
				chk(bresp, (a > `SFTP_CHB) ? 2'h2 : 2'h0);
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (tk)
				bready <= 1'b0;
		end
		if (!tk)
			to_out;
	endtask
	// Bus read into rd_v
	task automatic axr(input [7:0] a);
		logic ta, tk;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tk = 1'b0;
		for (int n = 0; n < 200 && !tk; n++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tk = rvalid && rready;
			if (tk)
				chk(rresp, (a > `SFTP_CHB) ? 2'h2 : 2'h0);
			rd_v = rdata;
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
			if (tk)
				rready <= 1'b0;
		end
		if (!tk)
			to_out;
	endtask
	// Next byte the peer took from the engine
	task automatic txb(input [7:0] e);
		for (int n = 0; n < 400 && peer.got.size() == 0; n++)
			@(posedge aclk);
		if (peer.got.size() == 0)
			to_out;
		chk(peer.got.pop_front(), e);
	endtask
	// One checked frame: start, text, end, check, optional XON
	task automatic frm(input [7:0] s, input [7:0] t, input [7:0] e,
		input x);
		txb(s);
		txb(t);
		txb(e);
		txb((s ^ t ^ e) & 8'h7f);
		if (x)
			txb(`SFTP_XON);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values and unmapped place
		axr(`SFTP_CTRL);
		chk(rd_v, `SFTP_CTRL_RST);
		axr(`SFTP_CHA);
		chk(rd_v, `SFTP_CHA_RST);
		axr(`SFTP_CHB);
		chk(rd_v, `SFTP_CHB_RST);
		axr(8'h1c);
		chk(rd_v, 32'h0);
		axw(8'h1c, 32'h0000_00ff);
		// Command without lane 0 is ignored
		wstrb <= 4'he;
		axw(`SFTP_CMD, `SFTP_OP_OUT);
		wstrb <= 4'hf;
		axr(`SFTP_STAT);
		chk(rd_v[3:0], 4'h0);
		// Plain directory, stream lands, then abort
		axw(`SFTP_CMD, `SFTP_OP_DIR);
		txb(`SFTP_XON);
		peer.snd.push_back(8'h50);
		repeat (10) @(posedge aclk);
		axr(`SFTP_RXD);
		chk(rd_v, 32'h0000_0150);
		txb(`SFTP_XOFF);
		txb(`SFTP_XON);
		axw(`SFTP_CMD, `SFTP_OP_ABORT);
		txb(8'h03);
		txb(8'h04);
		// Plain output under a slow port and peer XOFF
		peer.slow <= 1'b1;
		axw(`SFTP_CMD, `SFTP_OP_OUT);
		for (i = 0; i < `SFTP_NUL_CNT; i++)
			txb(`SFTP_NUL);
		peer.snd.push_back(`SFTP_XOFF);
		repeat (10) @(posedge aclk);
		axr(`SFTP_STAT);
		chk(rd_v[6], 1'b1);
		axw(`SFTP_TXD, 32'h41);
		repeat (20) @(posedge aclk);
		chk(peer.got.size(), 0);
		peer.snd.push_back(`SFTP_XON);
		txb(8'h41);
		axw(`SFTP_CMD, `SFTP_OP_FIN);
		txb(8'h03);
		txb(8'h04);
		peer.slow <= 1'b0;
		// Fixed checked header: four refusals end in error
		axw(`SFTP_CTRL, `SFTP_M_FIX);
		axw(`SFTP_TXD, 32'hd8);
		axw(`SFTP_CMD, 32'h0c);
		for (i = 0; i < 4; i++) begin
			frm(8'h01, 8'h58, 8'h17, 1'b1);
			peer.snd.push_back(8'h15);
		end
		txb(8'h04);
		axr(`SFTP_STAT);
		chk(rd_v[4], 1'b1);
		axw(`SFTP_CMD, `SFTP_OP_CLR);
		axr(`SFTP_STAT);
		chk(rd_v[4], 1'b0);
		// Text block: one refusal, resend, late accept
		axw(`SFTP_TXD, 32'h58);
		axw(`SFTP_CMD, `SFTP_OP_FRAME);
		frm(8'h02, 8'h58, 8'h17, 1'b1);
		peer.snd.push_back(8'h15);
		frm(8'h02, 8'h58, 8'h17, 1'b1);
		repeat (30) @(posedge aclk);
		peer.snd.push_back(8'h06);
		repeat (10) @(posedge aclk);
		axr(`SFTP_STAT);
		chk(rd_v[3:0], 4'h0);
		// Peer error frame: text reaches software, then ACK
		peer.snd.push_back(8'h01);
		peer.snd.push_back(8'h45);
		peer.snd.push_back(8'h17);
		peer.snd.push_back(8'h53);
		repeat (10) @(posedge aclk);
		axr(`SFTP_RXD);
		chk(rd_v, 32'h0000_0145);
		txb(8'h06);
		// Mode 3 checked, own characters, XON after check off
		axw(`SFTP_CTRL, 32'h13);
		axw(`SFTP_CHA, 32'h2a26_2221);
		axr(`SFTP_CHA);
		chk(rd_v, 32'h2a26_2221);
		axw(`SFTP_CMD, `SFTP_OP_CLR);
		axw(`SFTP_TXD, 32'h58);
		axw(`SFTP_CMD, `SFTP_OP_FRAME);
		frm(8'h22, 8'h58, 8'h26, 1'b0);
		peer.snd.push_back(8'h2a);
		repeat (20) @(posedge aclk);
		chk(peer.got.size(), 0);
		axr(`SFTP_STAT);
		chk(rd_v[3:0], 4'h0);
		// Plain read-in paced by the handshake line
		axw(`SFTP_CTRL, 32'h8);
		axw(`SFTP_CMD, `SFTP_OP_IN);
		txb(`SFTP_XON);
		peer.snd.push_back(8'h41);
		repeat (10) @(posedge aclk);
		chk(link_rts, 1'b0);
		axr(`SFTP_RXD);
		chk(rd_v, 32'h0000_0141);
		repeat (5) @(posedge aclk);
		chk(link_rts, 1'b1);
		axw(`SFTP_CMD, `SFTP_OP_INEND);
		txb(8'h04);
		// Directory mode request sequence, then reset again
		axw(`SFTP_CTRL, `SFTP_M_DIR);
		axw(`SFTP_CMD, `SFTP_OP_DIR);
		for (i = 0; i < 8; i++)
			txb(dir_seq[i]);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		peer.got.delete();
		axr(`SFTP_CTRL);
		chk(rd_v, `SFTP_CTRL_RST);
		print_verdict;
	end
endmodule // test_serial_file_transfer_protocol
